/* dmx_pkg.sv */
// Package for the data-move instruction execute block: encodings, phases and carriers.
package dmx_pkg;
    localparam logic [3:0]  OP_COPY_SRC    = 4'hc;
    localparam logic [3:0]  OP_COPY_DST    = 4'hf;
    localparam logic [7:0]  OP_LOAD_BANK   = 8'h01;
    localparam logic [7:0]  OP_LOAD_ACC    = 8'h0e;
    localparam logic [5:0]  OP_COPY_REG    = 6'h14;
    localparam logic [11:0] ACC_ADDR       = 12'hfe8;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
    localparam logic [7:0]  ACC_RESET      = 8'h00;
    localparam logic [3:0]  BANK_RESET     = 4'h0;
    localparam logic [11:0] ADDR_RESET     = 12'h000;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } dmx_phase_e;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } dmx_mem_s;

    typedef struct packed {
        logic neg;
        logic zero;
        logic we;
    } dmx_flag_s;
endpackage : dmx_pkg

/* dmx_exec.sv */
// Execute logic for the full-address copy, bank and accumulator literal loads and register copy.
// Notes on behaviour
// - A full-address copy reads the source byte and writes that same byte to the destination.
// - Source and destination addresses are 12 bits and reach the whole 4096-byte data space.
// - The accumulator may be the source or the destination of the full-address copy.
// - The full-address copy is two words, opcode 1100 then 1111, taking two instruction cycles.
// - The bank literal load writes the literal low nibble into the bank selector, whose top four bits read zero.
// - The accumulator literal load puts the literal in the accumulator in one cycle and touches no flags.
// - The register copy moves register f to the accumulator when d is 0 or back to f when d is 1, setting N and Z.
// - With a at 0 the access bank is used, with a at 1 the bank selector picks the register bank.
module dmx_exec
    import dmx_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [15:0] instr,
    input  wire logic        instr_valid,
    input  wire logic [1:0]  phase,
    input  wire logic [7:0]  mem_rdata,
    output dmx_mem_s         mem,
    output dmx_flag_s        flags,
    output logic [7:0]       accumulator,
    output logic [7:0]       bank_selector,
    output logic             copy_busy
);

////////////////////////////////////////////////////////////////////////////////
    // The copy sequencer only needs to know which word of a full-address copy is on the bus.
    typedef enum logic {
        CP_FIRST  = 1'b0,
        CP_SECOND = 1'b1
    } dmx_copy_e;

    dmx_phase_e  cur_phase;
    logic        in_q1;
    logic        in_q2;
    logic        in_q3;
    logic        in_q4;
    logic        dec_copy_src;
    logic        dec_copy_dst;
    logic        dec_copy_reg;
    logic        dec_load_bank;
    logic        dec_load_acc;
    logic        reg_to_acc;
    logic        acc_is_src;
    logic [11:0] access_addr;
    logic [11:0] reg_addr;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [7:0]  src_byte;
    dmx_copy_e   copy_state;
    dmx_copy_e   next_copy_state;
    logic [7:0]  latch_data;
    logic [7:0]  next_latch_data;
    dmx_mem_s    mem_q;
    dmx_mem_s    next_mem_q;
    logic [7:0]  acc_q;
    logic [7:0]  next_acc_q;
    logic [3:0]  bank_q;
    logic [3:0]  next_bank_q;
    dmx_flag_s   flag_q;
    dmx_flag_s   next_flag_q;

////////////////////////////////////////////////////////////////////////////////
    // Every decode is gated by the copy state, so the second copy word can never start an instruction.
    // Accumulator is memory mapped, so reads of its address are served locally.
    always_comb begin
        cur_phase     = dmx_phase_e'(phase);
        in_q1         = instr_valid && (cur_phase == PH_Q1);
        in_q2         = instr_valid && (cur_phase == PH_Q2);
        in_q3         = instr_valid && (cur_phase == PH_Q3);
        in_q4         = instr_valid && (cur_phase == PH_Q4);
        dec_copy_src  = (copy_state == CP_FIRST) && (instr[15:12] == OP_COPY_SRC);
        dec_copy_dst  = (copy_state == CP_SECOND) && (instr[15:12] == OP_COPY_DST);
        dec_copy_reg  = (copy_state == CP_FIRST) && (instr[15:10] == OP_COPY_REG);
        dec_load_bank = (copy_state == CP_FIRST) && (instr[15:8] == OP_LOAD_BANK);
        dec_load_acc  = (copy_state == CP_FIRST) && (instr[15:8] == OP_LOAD_ACC);
        if (instr[7:0] < ACCESS_SPLIT) begin
            access_addr = {4'h0, instr[7:0]};
        end else begin
            access_addr = {ACCESS_HI_BANK, instr[7:0]};
        end
        if (instr[8]) begin
            reg_addr = {bank_q, instr[7:0]};
        end else begin
            reg_addr = access_addr;
        end
        src_addr      = dec_copy_src ? instr[11:0] : reg_addr;
        dst_addr      = instr[11:0];
        reg_to_acc    = !instr[9] || (reg_addr == ACC_ADDR);
        acc_is_src    = (mem_q.addr == ACC_ADDR);
        src_byte      = acc_is_src ? acc_q : mem_rdata;
    end

////////////////////////////////////////////////////////////////////////////////
    // The stretched three-cycle form of the copy is not modelled; the second word always ends it.
    always_comb begin
        next_copy_state = copy_state;
        if (in_q4) begin
            unique case (copy_state)
                CP_FIRST: begin
                    if (dec_copy_src) begin
                        next_copy_state = CP_SECOND;
                    end
                end
                CP_SECOND: begin
                    next_copy_state = CP_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            copy_state <= CP_FIRST;
        end else begin
            copy_state <= next_copy_state;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_latch_data = latch_data;
        if (in_q2 && (dec_copy_src || dec_copy_reg)) begin
            next_latch_data = src_byte;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            latch_data <= ACC_RESET;
        end else begin
            latch_data <= next_latch_data;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Strobes are one clock wide; a write shows during the final quarter of the cycle.
    always_comb begin
        next_mem_q    = mem_q;
        next_mem_q.rd = 1'b0;
        next_mem_q.wr = 1'b0;
        if (in_q1 && (dec_copy_src || dec_copy_reg)) begin
            next_mem_q.addr = src_addr;
            next_mem_q.rd   = (src_addr != ACC_ADDR);
        end else if (in_q3 && dec_copy_dst) begin
            next_mem_q.addr = dst_addr;
            if (dst_addr != ACC_ADDR) begin
                next_mem_q.wr    = 1'b1;
                next_mem_q.wdata = latch_data;
            end
        end else if (in_q3 && dec_copy_reg && !reg_to_acc) begin
            next_mem_q.wr    = 1'b1;
            next_mem_q.wdata = latch_data;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mem_q <= '{rd: 1'b0, wr: 1'b0, addr: ADDR_RESET, wdata: ACC_RESET};
        end else begin
            mem_q <= next_mem_q;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_acc_q = acc_q;
        if (in_q3 && dec_copy_dst && (dst_addr == ACC_ADDR)) begin
            next_acc_q = latch_data;
        end else if (in_q3 && dec_copy_reg && reg_to_acc) begin
            next_acc_q = latch_data;
        end else if (in_q3 && dec_load_acc) begin
            next_acc_q = instr[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= ACC_RESET;
        end else begin
            acc_q <= next_acc_q;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_bank_q = bank_q;
        if (in_q3 && dec_load_bank) begin
            next_bank_q = instr[3:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bank_q <= BANK_RESET;
        end else begin
            bank_q <= next_bank_q;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Only the register copy touches the flags; both literal loads leave them alone.
    always_comb begin
        next_flag_q    = flag_q;
        next_flag_q.we = 1'b0;
        if (in_q3 && dec_copy_reg) begin
            next_flag_q.we   = 1'b1;
            next_flag_q.zero = (latch_data == 8'h00);
            next_flag_q.neg  = latch_data[7];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flag_q <= '{neg: 1'b0, zero: 1'b0, we: 1'b0};
        end else begin
            flag_q <= next_flag_q;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    assign mem           = mem_q;
    assign flags         = flag_q;
    assign accumulator   = acc_q;
    assign bank_selector = {4'h0, bank_q};
    assign copy_busy     = (copy_state == CP_SECOND);
endmodule : dmx_exec

/* dmx_exec_properties.sv */
// Checker for the data-move execute block, bound to its ports.
module dmx_exec_properties
    import dmx_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [15:0] instr,
    input wire logic        instr_valid,
    input wire logic [1:0]  phase,
    input wire logic [7:0]  mem_rdata,
    input wire dmx_mem_s    mem,
    input wire dmx_flag_s   flags,
    input wire logic [7:0]  accumulator,
    input wire logic [7:0]  bank_selector,
    input wire logic        copy_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // The busy term keeps a second copy word from looking like a fresh instruction.
    wire q1 = instr_valid && phase == PH_Q1 && !copy_busy;
    wire q3 = instr_valid && phase == PH_Q3 && !copy_busy;
    a_bank_top_zero: assert property (bank_selector[7:4] == 4'h0) else $error("bank top set");
    a_read_in_q2: assert property (mem.rd |-> phase == PH_Q2 ##1 !mem.rd) else $error("bad read");
    a_write_in_q4: assert property (mem.wr |-> phase == PH_Q4 ##1 !mem.wr) else $error("bad write");
    a_flag_in_q4: assert property (flags.we |-> phase == PH_Q4) else $error("bad flag write");
    a_acc_literal: assert property (q3 && instr[15:8] == OP_LOAD_ACC |=>
        accumulator == $past(instr[7:0]) && !flags.we) else $error("acc literal");
    a_bank_literal: assert property (q3 && instr[15:8] == OP_LOAD_BANK |=>
        bank_selector == {4'h0, $past(instr[3:0])}) else $error("bank literal");
    a_copy_src_read: assert property (q1 && instr[15:12] == OP_COPY_SRC && instr[11:0] != ACC_ADDR |=>
        mem.rd && mem.addr == $past(instr[11:0])) else $error("copy read");
    a_copy_two_cycles: assert property (q1 && instr[15:12] == OP_COPY_SRC |->
        ##4 copy_busy [*4]) else $error("copy length");
    a_second_no_read: assert property (copy_busy |-> !mem.rd) else $error("second word read");
    c_mem_write: cover property (mem.wr);
    c_flag_write: cover property (flags.we);
    c_copy_end: cover property (copy_busy ##1 !copy_busy);
endmodule : dmx_exec_properties
////////////////////////////////////////////////////////////////////////////////
bind dmx_exec dmx_exec_properties u_props (.core_clk(core_clk), .resetn(resetn), .instr(instr),
    .instr_valid(instr_valid), .phase(phase), .mem_rdata(mem_rdata), .mem(mem), .flags(flags),
    .accumulator(accumulator), .bank_selector(bank_selector), .copy_busy(copy_busy));

/* dmx_exec_tb_top.sv */
// Self-checking bench for the data-move execute block.
module dmx_exec_tb_top
    import dmx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, resetn = 0, instr_valid = 0;
    logic [15:0] instr = 16'h0000;
    logic [1:0]  phase = 2'h0;
    logic [7:0]  mem_rdata = 8'h00, accumulator, bank_selector;
    logic        copy_busy;
    dmx_mem_s    mem;
    dmx_flag_s   flags;
    int          errors = 0, n_compared = 0;
    dmx_exec dut (.core_clk(core_clk), .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
        .phase(phase), .mem_rdata(mem_rdata), .mem(mem), .flags(flags), .accumulator(accumulator),
        .bank_selector(bank_selector), .copy_busy(copy_busy));
    initial forever #25 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    // One word over four phases; returns just after the Q3 edge, when writes are visible.
    task automatic cyc(input logic [15:0] w, input logic [7:0] rd);
        for (int p = 0; p < 4; p++) begin
            @(posedge core_clk);
            instr <= w;
            phase <= p[1:0];
            mem_rdata <= rd;
            instr_valid <= 1'b1;
        end
        #1;
    endtask : cyc
    task automatic t_literals();
        cyc(16'h0e5a, 8'h00);
        chk(accumulator === 8'h5a && flags.we === 1'b0, "acc literal");
        cyc(16'h01a7, 8'h00);
        chk(bank_selector === 8'h07, "bank literal");
        $display("test literals done");
    endtask : t_literals
    // Read data is inverted in the second word, so a stray re-read shows in the result.
    task automatic t_copy(input logic [11:0] src, input logic [11:0] dst, input logic [7:0] rd, input logic [7:0] exp);
        cyc({OP_COPY_SRC, src}, rd);
        cyc({OP_COPY_DST, dst}, ~rd);
        chk(copy_busy === 1'b1, "copy second cycle");
        if (dst == ACC_ADDR) chk(accumulator === exp, "copy to acc");
        else chk(mem.wr === 1'b1 && mem.addr === dst && mem.wdata === exp, "copy write");
        $display("test copy done");
    endtask : t_copy
    task automatic t_reg(input logic [15:0] w, input logic [7:0] rd, input logic [11:0] addr);
        cyc(w, rd);
        chk(mem.addr === addr, "reg address");
        if (!w[9]) chk(accumulator === rd, "reg to acc");
        else chk(mem.wr === 1'b1 && mem.wdata === rd, "reg to f");
        chk(flags === {rd[7], rd == 8'h00, 1'b1}, "reg flags");
        $display("test register copy done");
    endtask : t_reg
    // Reset lands while the copy waits for its second word; the sequencer must start over.
    task automatic t_reset_mid();
        cyc({OP_COPY_SRC, 12'h010}, 8'h99);
        @(posedge core_clk);
        resetn <= 1'b0;
        instr_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(copy_busy === 1'b0 && accumulator === ACC_RESET && bank_selector === 8'h00, "mid reset");
        resetn <= 1'b1;
        cyc(16'h0e33, 8'h00);
        chk(accumulator === 8'h33 && copy_busy === 1'b0, "after mid reset");
        $display("test mid reset done");
    endtask : t_reset_mid
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(posedge core_clk);
        chk(accumulator === ACC_RESET && bank_selector === 8'h00 && copy_busy === 1'b0, "reset");
        resetn <= 1'b1;
        t_literals();
        t_copy(12'hfff, 12'h000, 8'h3c, 8'h3c);
        t_copy(ACC_ADDR, 12'h0ff, 8'h11, 8'h5a);
        t_copy(12'h800, ACC_ADDR, 8'h81, 8'h81);
        t_reg(16'h5010, 8'h80, 12'h010);
        t_reg(16'h5120, 8'h00, 12'h720);
        t_reg(16'h5270, 8'h42, 12'hf70);
        t_reset_mid();
        conclude();
    end
endmodule : dmx_exec_tb_top
